/* File: ssf_ctl_model.sv */
// Controller model: collects inbound windows, presents outbound windows.
`timescale 1ns/10ps
`default_nettype none
module ssf_ctl_model (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Inbound windows.
    input  wire logic [127:0] inbound_transfer_window,
    input  wire logic         inbound_window_valid,
    input  wire logic         inbound_idle,
    input  wire logic [7:0]   seq_transfer_count,
    // Outbound windows.
    output var  logic [127:0] outbound_transfer_window,
    output var  logic         outbound_window_valid,
    output var  logic [4:0]   outbound_window_bytes,
    input  wire logic         outbound_window_ready
);
    logic [127:0] wq[$];
    logic [7:0]   seq_acknowledge_echo;

    // Nothing offered until a window is sent.
    initial begin
        outbound_transfer_window = 128'h0;
        outbound_window_valid = 1'b0;
        outbound_window_bytes = 5'h01;
    end

    // Windows are kept only in count order; a jump stalls the model.
    // in-order acknowledge
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            seq_acknowledge_echo <= 8'h00;
        end else if (inbound_window_valid && !inbound_idle
                && seq_transfer_count == seq_acknowledge_echo + 8'h01) begin
            wq.push_back(inbound_transfer_window);
            seq_acknowledge_echo <= seq_transfer_count;
        end
    end

    // Window is held until taken or 200 clocks pass, then the lines show a changed pattern.
    // outbound framing
    task automatic send(input logic [127:0] w, input logic [4:0] n);
        int i;
        bit ok;
        ok = 1'b0;
        @(negedge sys_clk);
        outbound_transfer_window = w;
        outbound_window_bytes = n;
        outbound_window_valid = 1'b1;
        ok = (outbound_window_ready === 1'b1);
        for (i = 0; i < 200 && !ok; i++) begin
            @(negedge sys_clk);
            ok = (outbound_window_ready === 1'b1);
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        outbound_window_valid = 1'b0;
        outbound_transfer_window = ~w;
    endtask
endmodule // ssf_ctl_model
`default_nettype wire

/* File: ssf_ctrl_enc.v */
// Control byte encoder and segment length limit for the inbound framer.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_map.vh"
module ssf_ctrl_enc (
    // Segment description.
    input  wire [5:0] count,
    input  wire       last,
    // Window geometry and options.
    input  wire [4:0] width,
    input  wire [4:0] pos,
    input  wire       packed_on,
    input  wire       large_on,
    // Results.
    output wire [7:0] ctrl_byte,
    output reg  [5:0] limit
);

    wire next_flag;
    wire [4:0] room_less_one;
    wire [4:0] width_less_one;

    // flag when payload // same with both options.
    assign next_flag = packed_on & (count != 6'h00);

    // byte value sum // field layout.
    assign ctrl_byte = {last, next_flag, count};

    assign room_less_one  = width - pos - 5'h01;
    assign width_less_one = width - 5'h01;

    // large cap // standard fit // long messages still split.
    always @* begin
        limit = {1'b0, width_less_one};
        if (large_on) begin
            limit = `SSF_LARGE_MAX;
        end else if (packed_on) begin
            limit = {1'b0, room_less_one};
        end
    end

endmodule // ssf_ctrl_enc
`default_nettype wire

/* File: ssf_framer.v */
// Segment framer top: inbound window builder and outbound window parser.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_map.vh"
module ssf_framer (
    // Clock, reset and enable.
    input  wire         sys_clk,
    input  wire         rstn,
    input  wire         ce,
    // Inbound configuration.
    input  wire         packed_window_option,
    input  wire         large_segment_option,
    input  wire [4:0]   inbound_window_bytes,
    // Message bytes from the device logic.
    input  wire [7:0]   tx_data,
    input  wire         tx_valid,
    input  wire         tx_last,
    output reg          tx_ready,
    // Bus cycle tick.
    input  wire         bus_tick,
    // Inbound transfer window.
    output wire [127:0] inbound_transfer_window,
    output reg          inbound_window_valid,
    output reg          inbound_idle,
    output reg  [7:0]   seq_transfer_count,
    // Outbound transfer window.
    input  wire [127:0] outbound_transfer_window,
    input  wire         outbound_window_valid,
    input  wire [4:0]   outbound_window_bytes,
    output reg          outbound_window_ready,
    // Received message bytes.
    output reg  [7:0]   rx_data,
    output reg          rx_valid,
    output reg          rx_last
);

    // Framer states.
    localparam [2:0] S_COLLECT = 3'd0;
    localparam [2:0] S_CB      = 3'd1;
    localparam [2:0] S_RD      = 3'd2;
    localparam [2:0] S_WR      = 3'd3;
    localparam [2:0] S_CLOSE   = 3'd4;

    reg  [2:0] state;
    reg  [2:0] resume;
    reg  [4:0] pos;
    reg  [5:0] seg_cnt;
    reg  [5:0] sent;
    reg        seg_last;
    reg        opt_pk;
    reg        opt_lg;
    reg  [4:0] width_q;

    wire [7:0] ctrl_byte;
    wire [5:0] limit;
    wire [7:0] mem_q;
    wire       accept;
    wire       seg_end;
    wire       win_full;
    wire       seg_done;
    wire       room_two;
    wire       publish;
    wire       idle_pub;
    wire       part_pub;
    wire       wr_en;
    wire [7:0] wr_data;
    wire       rd_en;
    wire [4:0] width_clamp;
    wire [4:0] pos_inc;

    assign accept   = tx_valid & tx_ready;
    // collection stops at the limit // or at message end.
    assign seg_end  = accept & (tx_last | ((seg_cnt + 6'h01) == limit));
    assign win_full = (pos == (width_q - 5'h01));
    assign seg_done = ((sent + 6'h01) == seg_cnt);
    assign pos_inc  = pos + 5'h01;
    assign room_two = ((width_q - pos_inc) >= 5'h02);
    assign idle_pub = (state == S_COLLECT) & (seg_cnt == 6'h00) &
                      (pos == 5'h00) & ~tx_valid & bus_tick;
    // a part-filled window waits while bytes are pending.
    assign part_pub = (state == S_COLLECT) & (seg_cnt == 6'h00) &
                      (pos != 5'h00) & ~tx_valid & bus_tick;
    assign publish  = ((state == S_CLOSE) & bus_tick) | part_pub;
    assign wr_en    = (state == S_CB) | (state == S_WR);
    assign wr_data  = (state == S_CB) ? ctrl_byte : mem_q;
    assign rd_en    = (state == S_RD);

    // Inbound width kept inside what the window can hold.
    assign width_clamp = (inbound_window_bytes < `SSF_WIN_MIN_IN) ?
                         `SSF_WIN_MIN_IN :
                         (inbound_window_bytes > `SSF_WIN_MAX_W) ?
                         `SSF_WIN_MAX_W : inbound_window_bytes;

    ssf_ctrl_enc u_enc (
        .count     (seg_cnt),
        .last      (seg_last),
        .width     (width_q),
        .pos       (pos),
        .packed_on (opt_pk),
        .large_on  (opt_lg),
        .ctrl_byte (ctrl_byte),
        .limit     (limit)
    );

    ssf_seg_mem u_mem (
        .sys_clk (sys_clk),
        .ce      (ce),
        .wr_en   (accept),
        .wr_addr (seg_cnt),
        .wr_data (tx_data),
        .rd_en   (rd_en),
        .rd_addr (sent),
        .rd_data (mem_q)
    );

    // Options are taken only between segments so one segment never mixes.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            opt_pk  <= `SSF_PACKED_RST;
            opt_lg  <= `SSF_LARGE_RST;
            width_q <= `SSF_WIDTH_RST;
        end else if (ce) begin
            // inbound needs enables // both together
            if ((state == S_COLLECT) && (seg_cnt == 6'h00) && !accept &&
                (pos == 5'h00)) begin
                opt_pk  <= packed_window_option;
                opt_lg  <= large_segment_option;
                width_q <= width_clamp;
            end
        end
    end

    // Framing sequencer: collect a segment, then write its bytes in place.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= S_COLLECT;
            resume   <= S_COLLECT;
            pos      <= 5'h00;
            seg_cnt  <= 6'h00;
            sent     <= 6'h00;
            seg_last <= 1'b0;
            tx_ready <= 1'b0;
        end else if (ce) begin
            tx_ready <= 1'b0;
            case (state)
                S_COLLECT: begin
                    if (part_pub) begin
                        pos      <= 5'h00;
                    end else if (seg_end) begin
                        seg_cnt  <= seg_cnt + 6'h01;
                        seg_last <= tx_last;
                        state    <= S_CB;
                    end else begin
                        if (accept) begin
                            seg_cnt <= seg_cnt + 6'h01;
                        end
                        tx_ready <= 1'b1;
                    end
                end
                S_CB: begin
                    sent <= 6'h00;
                    pos  <= pos_inc;
                    if (win_full) begin
                        resume <= S_RD;
                        state  <= S_CLOSE;
                    end else begin
                        state  <= S_RD;
                    end
                end
                S_RD: begin
                    state <= S_WR;
                end
                S_WR: begin
                    sent <= sent + 6'h01;
                    pos  <= pos_inc;
                    if (seg_done) begin
                        seg_cnt <= 6'h00;
                        if (!win_full && opt_pk && room_two && tx_valid) begin
                            state <= S_COLLECT;
                        end else begin
                            resume <= S_COLLECT;
                            state  <= S_CLOSE;
                        end
                    end else if (win_full) begin
                        resume <= S_RD;
                        state  <= S_CLOSE;
                    end else begin
                        state <= S_RD;
                    end
                end
                S_CLOSE: begin
                    if (bus_tick) begin
                        // next window opens at byte zero
                        pos   <= 5'h00;
                        state <= resume;
                    end
                end
                default: begin
                    state <= S_COLLECT;
                end
            endcase
        end
    end

    // Staging and published window bytes, one register pair per position.
    genvar gi;
    generate
        for (gi = 0; gi < `SSF_WIN_MAX; gi = gi + 1) begin : g_byte
            reg [7:0] out_byte;
            reg [7:0] stage_byte;
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    stage_byte <= 8'h00;
                    out_byte   <= 8'h00;
                end else if (ce) begin
                    if (publish) begin
                        out_byte   <= stage_byte;
                        stage_byte <= 8'h00;
                    end else if (idle_pub) begin
                        out_byte   <= (gi == 0) ? `SSF_IDLE_CB : 8'h00;
                    end else if (wr_en && (pos == gi)) begin
                        stage_byte <= wr_data;
                    end
                end
            end
            assign inbound_transfer_window[8*gi+7:8*gi] = out_byte;
        end
    endgenerate

    // Window strobe, idle mark and sequence count.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            inbound_window_valid <= 1'b0;
            inbound_idle         <= 1'b0;
            seq_transfer_count   <= `SSF_SEQ_RST;
        end else if (ce) begin
            inbound_window_valid <= publish | idle_pub;
            inbound_idle         <= idle_pub;
            if (publish) begin
                seq_transfer_count <= seq_transfer_count + 8'h01;
            end
        end
    end

    // Outbound parser state.
    reg [127:0] cap;
    reg         busy;
    reg [4:0]   idx;
    reg [4:0]   owid;
    reg [5:0]   remain;
    reg         p_next;
    reg         p_last;
    reg         expect_cb;
    reg         stop;

    wire [7:0]  cur_byte;
    wire        ob_accept;
    wire [4:0]  ow_clamp;

    assign cur_byte  = cap[{idx[3:0], 3'b000} +: 8];
    assign ob_accept = outbound_window_valid & outbound_window_ready;
    assign ow_clamp  = (outbound_window_bytes < `SSF_WIN_MIN_OUT) ?
                       `SSF_WIN_MIN_OUT :
                       (outbound_window_bytes > `SSF_WIN_MAX_W) ?
                       `SSF_WIN_MAX_W : outbound_window_bytes;

    // Parse stop: a segment ends without a next flag, an empty control
    // byte is met, or a byte is neither payload nor control.
    always @* begin
        stop = 1'b0;
        if (remain != 6'h00) begin
            stop = (remain == 6'h01) & ~p_next;
        end else if (expect_cb) begin
            stop = (cur_byte[`SSF_CNT_MSB:0] == 6'h00) &
                   ~cur_byte[`SSF_NEXT_BIT];
        end else begin
            stop = 1'b1;
        end
    end

    // outbound parse always accepts packed and large forms.
    always @(posedge sys_clk or negedge rstn) begin : p_parse
        if (!rstn) begin
            cap       <= 128'h0;
            busy      <= 1'b0;
            idx       <= 5'h00;
            owid      <= `SSF_WIN_MIN_OUT;
            remain    <= 6'h00;
            p_next    <= 1'b0;
            p_last    <= 1'b0;
            expect_cb <= 1'b0;
            rx_data   <= 8'h00;
            rx_valid  <= 1'b0;
            rx_last   <= 1'b0;
            outbound_window_ready <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            rx_last  <= 1'b0;
            if (!busy) begin
                outbound_window_ready <= 1'b1;
                if (ob_accept) begin
                    cap  <= outbound_transfer_window;
                    owid <= ow_clamp;
                    idx  <= 5'h00;
                    busy <= 1'b1;
                    outbound_window_ready <= 1'b0;
                    // window may continue a segment with payload only
                    expect_cb <= (remain == 6'h00);
                end
            end else begin
                if (remain != 6'h00) begin
                    rx_data  <= cur_byte;
                    rx_valid <= 1'b1;
                    remain   <= remain - 6'h01;
                    if (remain == 6'h01) begin
                        rx_last   <= p_last;
                        // next flag locates next control byte
                        expect_cb <= p_next;
                    end
                end else if (expect_cb) begin
                    if (cur_byte != `SSF_IDLE_CB) begin
                        // field split // decode of the sum
                        remain <= cur_byte[`SSF_CNT_MSB:0];
                        p_next <= cur_byte[`SSF_NEXT_BIT];
                        p_last <= cur_byte[`SSF_LAST_BIT];
                    end
                end
                idx <= idx + 5'h01;
                if (stop || (idx == (owid - 5'h01))) begin
                    busy <= 1'b0;
                    outbound_window_ready <= 1'b1;
                end
            end
        end
    end

endmodule // ssf_framer
`default_nettype wire

/* File: ssf_framer_assertions.sv */
// Port checker for the segment framer.
`timescale 1ns/10ps
`default_nettype none
module ssf_framer_assertions (
    // Clock and reset.
    input wire logic         sys_clk,
    input wire logic         rstn,
    // Inbound side.
    input wire logic         packed_window_option,
    input wire logic         large_segment_option,
    input wire logic [4:0]   inbound_window_bytes,
    input wire logic [127:0] inbound_transfer_window,
    input wire logic         inbound_window_valid,
    input wire logic         inbound_idle,
    input wire logic [7:0]   seq_transfer_count,
    // Outbound side.
    input wire logic [127:0] outbound_transfer_window,
    input wire logic         outbound_window_valid,
    input wire logic         outbound_window_ready,
    input wire logic         rx_valid,
    input wire logic         rx_last
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // A non-idle window published, and a standard-mode and a packed-mode one.
    sequence pub_s;
        inbound_window_valid && !inbound_idle;
    endsequence
    sequence std_pub_s;
        pub_s ##0 (!packed_window_option && !large_segment_option);
    endsequence
    sequence pk_pub_s;
        pub_s ##0 (packed_window_option && !large_segment_option);
    endsequence
    // An outbound window taken by the framer.
    sequence take_s;
        outbound_window_valid && outbound_window_ready;
    endsequence

    idle_byte_a:
        assert property (inbound_idle |-> inbound_window_valid
            && inbound_transfer_window[7:0] == 8'h00)
        else $error("Idle window is not a bare idle byte.");
    idle_count_a:
        assert property (inbound_idle |-> $stable(seq_transfer_count))
        else $error("Idle window moved the sequence count.");
    count_step_a:
        assert property (pub_s |->
            seq_transfer_count == $past(seq_transfer_count) + 8'h01)
        else $error("Sequence count did not step by one.");
    std_next_a:
        assert property (std_pub_s |-> !inbound_transfer_window[6])
        else $error("Standard window has the next flag set.");
    pk_next_a:
        assert property (pk_pub_s |-> inbound_transfer_window[6]
            == (inbound_transfer_window[5:0] != 6'h00))
        else $error("Packed control byte has a wrong next flag.");
    std_len_a:
        assert property (std_pub_s |->
            inbound_transfer_window[5:0] != 6'h00
            && inbound_transfer_window[5:0] < {1'b0, inbound_window_bytes})
        else $error("Standard segment does not fit its window.");
    rx_last_a:
        assert property (rx_last |-> rx_valid)
        else $error("Last marker without a byte.");
    out_busy_a:
        assert property (take_s |=> !outbound_window_ready)
        else $error("Outbound ready stayed high after a take.");
    rx_start_a:
        assert property (take_s ##0 (outbound_transfer_window[5:0] != 6'h00)
            |-> ##[2:3] rx_valid)
        else $error("No received byte after an outbound take.");
endmodule // ssf_framer_assertions
`default_nettype wire

/* File: ssf_map.vh */
// Constants for the segment framer: field layout, limits and reset values.
`ifndef SSF_MAP_VH
`define SSF_MAP_VH

// Control byte field positions.
`define SSF_CNT_MSB     5
`define SSF_NEXT_BIT    6
`define SSF_LAST_BIT    7

// Segment and window limits, and the idle control byte.
`define SSF_LARGE_MAX   6'h3F
`define SSF_IDLE_CB     8'h00
`define SSF_WIN_MAX     16
`define SSF_WIN_MAX_W   5'h10
`define SSF_WIN_MIN_IN  5'h02
`define SSF_WIN_MIN_OUT 5'h01

// Reset values.
`define SSF_PACKED_RST  1'b0
`define SSF_LARGE_RST   1'b0
`define SSF_SEQ_RST     8'h00
`define SSF_WIDTH_RST   5'h02

`endif

/* File: ssf_seg_mem.v */
// Segment buffer memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module ssf_seg_mem (
    // Clock and enable.
    input  wire       sys_clk,
    input  wire       ce,
    // Write port.
    input  wire       wr_en,
    input  wire [5:0] wr_addr,
    input  wire [7:0] wr_data,
    // Read port.
    input  wire       rd_en,
    input  wire [5:0] rd_addr,
    output reg  [7:0] rd_data
);

    reg [7:0] mem [0:63];

    // Storage holds no reset; only written bytes are ever read back.
    always @(posedge sys_clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= mem[rd_addr];
            end
        end
    end

endmodule // ssf_seg_mem
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the segment framer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic         sys_clk = 1'b0;
    logic         rstn = 1'b0;
    logic         packed_window_option = 1'b0;
    logic         large_segment_option = 1'b0;
    logic [4:0]   inbound_window_bytes = 5'h04;
    logic [7:0]   tx_data = 8'h00;
    logic         tx_valid = 1'b0;
    logic         tx_last = 1'b0;
    logic         bus_tick = 1'b0;
    wire          tx_ready, inbound_window_valid, inbound_idle;
    wire  [127:0] inbound_transfer_window, outbound_transfer_window;
    wire  [7:0]   seq_transfer_count, rx_data;
    wire  [4:0]   outbound_window_bytes;
    wire          outbound_window_valid, outbound_window_ready;
    wire          rx_valid, rx_last;
    int           bad_count = 0;
    int           checks_done = 0;
    int           cyc = 0;
    int           tcnt = 0;
    logic [7:0]   txq[$];
    bit           lq[$];
    logic [127:0] ew[$];
    logic [8:0]   rxq[$];

    ssf_framer dut (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1),
        .packed_window_option(packed_window_option),
        .large_segment_option(large_segment_option),
        .inbound_window_bytes(inbound_window_bytes), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .bus_tick(bus_tick), .inbound_transfer_window(inbound_transfer_window),
        .inbound_window_valid(inbound_window_valid),
        .inbound_idle(inbound_idle), .seq_transfer_count(seq_transfer_count),
        .outbound_transfer_window(outbound_transfer_window),
        .outbound_window_valid(outbound_window_valid),
        .outbound_window_bytes(outbound_window_bytes),
        .outbound_window_ready(outbound_window_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last));
    ssf_ctl_model ctl (.sys_clk(sys_clk), .rstn(rstn),
        .inbound_transfer_window(inbound_transfer_window),
        .inbound_window_valid(inbound_window_valid),
        .inbound_idle(inbound_idle), .seq_transfer_count(seq_transfer_count),
        .outbound_transfer_window(outbound_transfer_window),
        .outbound_window_valid(outbound_window_valid),
        .outbound_window_bytes(outbound_window_bytes),
        .outbound_window_ready(outbound_window_ready));

    // Clock, bus cycle every 40 clocks, received bytes and a run limit.
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        tcnt <= (tcnt == 39) ? 0 : tcnt + 1;
        bus_tick <= rstn && tcnt == 39;
        if (rx_valid === 1'b1) rxq.push_back({rx_last, rx_data});
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            end_sim;
        end
    end

    task chk(input logic [127:0] g, input logic [127:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, g, e);
        end
    endtask

    task end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Queue one message of n bytes counting up from b.
    task put(input logic [7:0] b, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            txq.push_back(b + 8'(i));
            lq.push_back(i == n - 1);
        end
    endtask

    // Set the options, stream the queued bytes, compare the windows.
    task frame(input logic [4:0] w, input bit pk, input bit lg);
        int i;
        bit rdy;
        @(negedge sys_clk);
        inbound_window_bytes = w;
        packed_window_option = pk;
        large_segment_option = lg;
        repeat (100) @(negedge sys_clk);
        ctl.wq.delete();
        while (txq.size() > 0) begin
            @(negedge sys_clk);
            tx_valid = 1'b1;
            tx_data = txq[0];
            tx_last = lq[0];
            rdy = (tx_ready === 1'b1);
            @(posedge sys_clk);
            if (rdy) begin
                void'(txq.pop_front());
                void'(lq.pop_front());
            end
        end
        @(negedge sys_clk);
        tx_valid = 1'b0;
        for (i = 0; i < 3000 && ctl.wq.size() < ew.size(); i++)
            @(posedge sys_clk);
        chk(128'(ctl.wq.size()), 128'(ew.size()));
        foreach (ew[k]) if (k < ctl.wq.size()) chk(ctl.wq[k], ew[k]);
        ew.delete();
    endtask

    // Default options: short segments, one message per window start.
    task t_std;
        put(8'h01, 2);
        put(8'h11, 5);
        ew = '{128'h020182, 128'h13121103, 128'h151482};
        frame(5'h04, 1'b0, 1'b0);
    endtask

    // Nothing pending: idle byte, count held.
    task t_idle;
        logic [7:0] c;
        int i;
        c = seq_transfer_count;
        for (i = 0; i < 100 && inbound_idle !== 1'b1; i++) @(negedge sys_clk);
        chk(128'(inbound_idle), 128'h1);
        chk(inbound_transfer_window, 128'h0);
        chk(128'(seq_transfer_count), 128'(c));
    endtask

    // Packed and large outbound forms with inbound options off.
    task t_out;
        logic [8:0] e[$];
        e = '{9'h0A1, 9'h0A2, 9'h1A3, 9'h0B1, 9'h0B2, 9'h0B3, 9'h0B4, 9'h1B5};
        rxq.delete();
        ctl.send(128'h0000A381A2A142, 5'h07);
        ctl.send(128'hB3B2B185, 5'h04);
        ctl.send(128'hB5B4, 5'h02);
        repeat (20) @(posedge sys_clk);
        chk(128'(rxq.size()), 128'(e.size()));
        foreach (e[k]) if (k < rxq.size()) chk(128'(rxq[k]), 128'(e[k]));
    endtask

    // Packed windows: three messages share windows.
    task t_packed;
        put(8'h01, 7);
        put(8'h21, 2);
        put(8'h31, 9);
        ew = '{128'h06050403020146, 128'h31412221C207C1,
               128'h37363534333246, 128'h3938C2};
        frame(5'h07, 1'b1, 1'b0);
    endtask

    // Both options: long segments that also share windows.
    task t_both;
        put(8'h01, 7);
        put(8'h21, 2);
        put(8'h31, 9);
        ew = '{128'h060504030201C7, 128'h3231C92221C207,
               128'h39383736353433};
        frame(5'h07, 1'b1, 1'b1);
    endtask

    // Large segments: a 64-byte message needs a second segment.
    task t_large;
        logic [127:0] w;
        int j;
        put(8'h01, 64);
        for (j = 0; j < 64; j++) begin
            w[8*(j%16)+:8] = (j == 0) ? 8'h3F : 8'(j);
            if (j % 16 == 15) ew.push_back(w);
        end
        ew.push_back(128'h4081);
        frame(5'h10, 1'b0, 1'b1);
    endtask

    // Reset for 8 clocks, then every scenario in turn.
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        repeat (20) @(negedge sys_clk);
        t_std;
        t_idle;
        t_out;
        t_packed;
        t_both;
        t_large;
        end_sim;
    end
endmodule // tb_top

bind ssf_framer ssf_framer_assertions sva (.sys_clk, .rstn,
    .packed_window_option, .large_segment_option, .inbound_window_bytes,
    .inbound_transfer_window, .inbound_window_valid, .inbound_idle,
    .seq_transfer_count, .outbound_transfer_window, .outbound_window_valid,
    .outbound_window_ready, .rx_valid, .rx_last);
`default_nettype wire
